/* rtl/bsens_pkg.sv */
package bsens_pkg;

    // Source slots: window contact 1, window contact 2, presence 1, presence 2, card holder
    localparam int NSRC = 5;
    localparam int SRC_WIN1 = 0;
    localparam int SRC_WIN2 = 1;
    localparam int SRC_PRES1 = 2;
    localparam int SRC_PRES2 = 3;
    localparam int SRC_CARD = 4;

    // Clock and second tick
    localparam int CLK_PERIOD_NS = 8;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;

    // Register word indices (byte address = 4 * index)
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_TIMEOUT = 6'h01;
    localparam logic [5:0] IDX_POLL0 = 6'h02;
    localparam logic [5:0] IDX_POLL4 = 6'h06;
    localparam logic [5:0] IDX_STATE = 6'h08;
    localparam logic [5:0] IDX_INT_STATUS = 6'h09;
    localparam logic [5:0] IDX_INT_CLEAR = 6'h0A;
    localparam logic [5:0] IDX_INT_ENABLE = 6'h0B;
    localparam logic [5:0] IDX_ALARM = 6'h0C;

    // Field positions
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_INV_LSB = 8;
    localparam int TO_SS_LSB = 0;
    localparam int TO_MM_LSB = 8;
    localparam int TO_HH_LSB = 16;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_STALE_LSB = 8;
    localparam int ST_SUSPEND_BIT = 16;
    localparam int INT_STALE_LSB = 0;
    localparam int INT_FRESH_LSB = 8;

    // Timeout in seconds: default 00:05:00, ceiling 18:12:15
    localparam logic [5:0] TO_MM_RST = 6'h05;
    localparam logic [15:0] TO_SEC_RST = 16'h012C;
    localparam logic [15:0] TO_MAX_S = 16'hFFFF;
    localparam logic [16:0] SEC_PER_HOUR = 17'h0_0E10;
    localparam logic [16:0] SEC_PER_MIN = 17'h0_003C;

    // Polling interval in seconds: 0 = no reading, else 30 s .. 120 min
    localparam logic [12:0] POLL_MIN_S = 13'h001E;
    localparam logic [12:0] POLL_MAX_S = 13'h1C20;

    // Alarm code shown for a stale source is base plus slot; base value is arbitrary
    localparam logic [7:0] ALARM_CODE_BASE = 8'h40;

    // Values arriving from the bus stack, same clock
    typedef struct packed {
        logic [NSRC-1:0] valid;
        logic [NSRC-1:0] value;
    } sensor_rx_t;

    // Indications toward regulation and display
    typedef struct packed {
        logic suspend;
        logic alarm;
        logic [7:0] code;
    } alarm_out_t;

endpackage

/* rtl/tick_gen.sv */
`timescale 1ns/1ps
// One-cycle enable pulse every CYCLES clocks
module tick_gen #(
    parameter int CYCLES = bsens_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    output logic tick
);

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t r;
    tick_state_t n;

    generate
        if (CYCLES < 2) begin : g_bad
            $error("tick_gen: CYCLES must be at least 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Wrap counter; compare against CYCLES-1 so the period is exact
    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (r.cnt >= 32'(CYCLES - 1)) begin
            n.cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;

endmodule // tick_gen

/* rtl/bus_binary_sensor_timeout.sv */
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module bus_binary_sensor_timeout #(
    parameter int TICK_CYCLES = bsens_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Sensor values from the bus stack
    input wire bsens_pkg::sensor_rx_t rx,
    output logic [bsens_pkg::NSRC-1:0] poll_req,
    output logic [bsens_pkg::NSRC-1:0] sensor_state,
    output bsens_pkg::alarm_out_t alarm_out,
    output logic irq
);

    localparam int N = bsens_pkg::NSRC;

    // Register map; the byte address is four times the word index:
    //   CTRL        RW  [4:0] source enable, [12:8] source invert
    //   TIMEOUT     RW  [5:0] seconds, [13:8] minutes, [20:16] hours
    //   POLL0..4    RW  [12:0] polling interval in seconds, 0 = no polling
    //   STATE       RO  [4:0] source states, [12:8] stale flags, [16] regulation held
    //   INT_STATUS  RO  [4:0] stale events, [12:8] fresh-value events
    //   INT_CLEAR   WO  a one clears the matching status bit; reads zero
    //   INT_ENABLE  RW  [15:0] interrupt mask over INT_STATUS
    //   ALARM       RO  [7:0] alarm code, zero while nothing is stale
    // Unmapped words read zero and drop writes; every answer is OKAY.
    // Polling intervals of 1 to 29 s read back as 30 s, above 120 min as 120 min.
    // The timeout total saturates at 18:12:15 whatever the fields hold.

    typedef struct packed {
        // Configuration
        logic [N-1:0] en;
        logic [N-1:0] inv;
        logic [5:0] to_ss;
        logic [5:0] to_mm;
        logic [4:0] to_hh;
        logic [15:0] to_sec;
        // Freshness window counter
        logic [15:0] to_cnt;
        // Per-source polling interval and counter
        logic [N-1:0][12:0] poll_iv;
        logic [N-1:0][12:0] poll_cnt;
        // Per-source received value and status
        logic [N-1:0] raw;
        logic [N-1:0] updated;
        logic [N-1:0] stale;
        logic [N-1:0] poll;
        logic [N-1:0] state;
        // Interrupt status and mask
        logic [15:0] int_st;
        logic [15:0] int_en;
        // Bus slave: captured address phase and answer
        logic ap_valid;
        logic ap_write;
        logic [5:0] ap_addr;
        logic ready;
        logic [31:0] rdata;
        // Indications toward regulation, display and software
        logic suspend;
        logic alarm;
        logic [7:0] code;
        logic irq;
    } core_t;

    // Registered state and its next value
    core_t r;
    core_t n;
    logic tick;

    generate
        if (TICK_CYCLES < 2) begin : g_bad
            $error("bus_binary_sensor_timeout: TICK_CYCLES must be at least 2");
        end
        // Status fields sit on an 8-bit stride and the poll index is 3 bits
        if (N < 1 || N > 8) begin : g_bad_n
            $error("bus_binary_sensor_timeout: NSRC must be 1 to 8");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Seconds base for timeout and polling
    // The tick runs free from reset, so a window or interval that starts
    // between ticks can be up to one tick shorter than its setting
    tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        // Working values; each is given a value before any use
        logic [N-1:0] fresh;
        logic [N-1:0] stale_ev;
        logic [15:0] clr;
        logic [16:0] secs;
        logic [12:0] iv;
        logic [2:0] pidx;
        logic [31:0] rd;
        fresh = '0;
        stale_ev = '0;
        clr = '0;
        secs = '0;
        iv = '0;
        pidx = '0;
        rd = '0;
        // Hold everything by default; pulses clear each cycle
        n = r;
        n.poll = '0;

        // Data phase takes one wait state so hrdata comes from a flop
        if (r.ap_valid) begin
            n.ap_valid = 1'b0;
            n.ready = 1'b1;
            pidx = 3'(r.ap_addr - bsens_pkg::IDX_POLL0);
            // Writes land at the end of the wait-state cycle, while hwdata stands
            if (r.ap_write) begin
                if (r.ap_addr == bsens_pkg::IDX_CTRL) begin
                    n.en = hwdata[bsens_pkg::CTRL_EN_LSB +: N];
                    n.inv = hwdata[bsens_pkg::CTRL_INV_LSB +: N];
                end else if (r.ap_addr == bsens_pkg::IDX_TIMEOUT) begin
                    n.to_ss = hwdata[bsens_pkg::TO_SS_LSB +: 6];
                    n.to_mm = hwdata[bsens_pkg::TO_MM_LSB +: 6];
                    n.to_hh = hwdata[bsens_pkg::TO_HH_LSB +: 5];
                    secs = 17'(n.to_hh) * bsens_pkg::SEC_PER_HOUR
                         + 17'(n.to_mm) * bsens_pkg::SEC_PER_MIN + 17'(n.to_ss);
                    // Settings past 18:12:15 saturate at the ceiling
                    if (secs > 17'(bsens_pkg::TO_MAX_S)) begin
                        n.to_sec = bsens_pkg::TO_MAX_S;
                    end else begin
                        n.to_sec = secs[15:0];
                    end
                    // A new setting restarts the window
                    n.to_cnt = '0;
                end else if (r.ap_addr >= bsens_pkg::IDX_POLL0 &&
                             r.ap_addr <= bsens_pkg::IDX_POLL4) begin
                    iv = hwdata[12:0];
                    // Out-of-range intervals are clamped rather than refused
                    if (hwdata[31:13] != '0 || iv > bsens_pkg::POLL_MAX_S) begin
                        iv = bsens_pkg::POLL_MAX_S;
                    end else if (iv != '0 && iv < bsens_pkg::POLL_MIN_S) begin
                        iv = bsens_pkg::POLL_MIN_S;
                    end
                    n.poll_iv[pidx] = iv;
                    // Restart this source's interval only
                    n.poll_cnt[pidx] = '0;
                end else if (r.ap_addr == bsens_pkg::IDX_INT_CLEAR) begin
                    clr = hwdata[15:0];
                end else if (r.ap_addr == bsens_pkg::IDX_INT_ENABLE) begin
                    n.int_en = hwdata[15:0];
                end
            end else begin
                // Read data is registered and holds until the next read
                if (r.ap_addr == bsens_pkg::IDX_CTRL) begin
                    rd[bsens_pkg::CTRL_EN_LSB +: N] = r.en;
                    rd[bsens_pkg::CTRL_INV_LSB +: N] = r.inv;
                end else if (r.ap_addr == bsens_pkg::IDX_TIMEOUT) begin
                    rd[bsens_pkg::TO_SS_LSB +: 6] = r.to_ss;
                    rd[bsens_pkg::TO_MM_LSB +: 6] = r.to_mm;
                    rd[bsens_pkg::TO_HH_LSB +: 5] = r.to_hh;
                end else if (r.ap_addr >= bsens_pkg::IDX_POLL0 &&
                             r.ap_addr <= bsens_pkg::IDX_POLL4) begin
                    rd[12:0] = r.poll_iv[pidx];
                end else if (r.ap_addr == bsens_pkg::IDX_STATE) begin
                    rd[bsens_pkg::ST_STATE_LSB +: N] = r.state;
                    rd[bsens_pkg::ST_STALE_LSB +: N] = r.stale;
                    rd[bsens_pkg::ST_SUSPEND_BIT] = r.suspend;
                end else if (r.ap_addr == bsens_pkg::IDX_INT_STATUS) begin
                    rd[15:0] = r.int_st;
                end else if (r.ap_addr == bsens_pkg::IDX_INT_ENABLE) begin
                    rd[15:0] = r.int_en;
                end else if (r.ap_addr == bsens_pkg::IDX_ALARM) begin
                    rd[7:0] = r.code;
                end
                n.rdata = rd;
            end
        end else if (hsel && hready && htrans[1]) begin
            // Address phase is taken only while the bus is ready; hsize is not checked
            n.ap_valid = 1'b1;
            n.ap_write = hwrite;
            n.ap_addr = haddr[7:2];
            n.ready = 1'b0;
        end

        // Received values; disabled sources are dropped entirely
        // A disabled source keeps its last raw value, but its state reads zero
        fresh = rx.valid & n.en;
        for (int i = 0; i < N; i++) begin
            if (fresh[i]) begin
                n.raw[i] = rx.value[i];
            end
        end
        n.updated = (r.updated | fresh) & n.en;
        n.stale = r.stale & ~fresh & n.en;

        // Polling counters, one per source, advanced on the second tick
        // Disabling a source or setting its interval to zero parks its counter
        for (int i = 0; i < N; i++) begin
            if (!n.en[i] || n.poll_iv[i] == '0) begin
                n.poll_cnt[i] = '0;
            end else if (tick) begin
                if (n.poll_cnt[i] + 13'h0001 >= n.poll_iv[i]) begin
                    n.poll_cnt[i] = '0;
                    n.poll[i] = 1'b1;
                end else begin
                    n.poll_cnt[i] = n.poll_cnt[i] + 13'h0001;
                end
            end
        end

        // Freshness window; zero timeout stops monitoring and drops stale flags
        // Resolution is one tick: the trade for a 16-bit counter over a cycle count
        if (n.to_sec == '0) begin
            n.to_cnt = '0;
            n.stale = '0;
            n.updated = '0;
        end else if (tick) begin
            if (n.to_cnt + 16'h0001 >= n.to_sec) begin
                // A value landing in the expiry cycle still counts for this window
                stale_ev = n.en & ~n.updated;
                n.stale = n.stale | stale_ev;
                n.updated = '0;
                n.to_cnt = '0;
            end else begin
                n.to_cnt = n.to_cnt + 16'h0001;
            end
        end

        // Sensor states with polarity applied
        n.state = (n.raw ^ n.inv) & n.en;

        // Regulation hold and alarm; lowest stale slot names the code
        // Suspend and alarm come from one term, so they can never disagree
        n.suspend = |n.stale;
        n.alarm = |n.stale;
        n.code = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (n.stale[i]) begin
                n.code = bsens_pkg::ALARM_CODE_BASE + 8'(i);
            end
        end

        // Sticky events: a new event wins over a clear in the same cycle
        // Fresh events are counted for enabled sources only
        n.int_st = (r.int_st & ~clr);
        n.int_st[bsens_pkg::INT_STALE_LSB +: N] = n.int_st[bsens_pkg::INT_STALE_LSB +: N]
                                                 | stale_ev;
        n.int_st[bsens_pkg::INT_FRESH_LSB +: N] = n.int_st[bsens_pkg::INT_FRESH_LSB +: N]
                                                 | fresh;
        n.irq = |(n.int_st & n.int_en);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // All clear except the five-minute timeout and an idle, ready bus
            r <= '0;
            r.to_mm <= bsens_pkg::TO_MM_RST;
            r.to_sec <= bsens_pkg::TO_SEC_RST;
            r.ready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register, except hresp tied to OKAY
    // Bus slave answer
    assign hrdata = r.rdata;
    assign hreadyout = r.ready;
    assign hresp = 1'b0; // Always OKAY
    // Toward the bus stack, the regulation and the display
    assign poll_req = r.poll;
    assign sensor_state = r.state;
    assign alarm_out.suspend = r.suspend;
    assign alarm_out.alarm = r.alarm;
    assign alarm_out.code = r.code;
    assign irq = r.irq;

endmodule // bus_binary_sensor_timeout

/* sim/bsens_assertions.sv */
`timescale 1ns/1ps
// Port-level relations of the binary sensor timeout block
module bsens_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire bsens_pkg::sensor_rx_t rx,
    input wire logic [bsens_pkg::NSRC-1:0] poll_req,
    input wire logic [bsens_pkg::NSRC-1:0] sensor_state,
    input wire bsens_pkg::alarm_out_t alarm_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    // A taken transfer gets exactly one wait state
    sequence s_take;
        hsel && hready && htrans[1];
    endsequence
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    AST_WAIT: assert property (s_take |=> s_wait)
        else $error("wait state missing");
    AST_IDLE_READY: assert property (!(hsel && hready && htrans[1]) && hreadyout |=> hreadyout)
        else $error("ready dropped without transfer");
    AST_RESP: assert property (hresp == 1'b0)
        else $error("response not okay");
    ////////////////////////////////////////////////////////////////////////////////
    // Alarm, suspend and code move together
    AST_SUSPEND: assert property (alarm_out.alarm == alarm_out.suspend)
        else $error("suspend and alarm differ");
    AST_CODE: assert property (alarm_out.alarm ?
        (alarm_out.code inside {[8'h40:8'h44]}) : (alarm_out.code == 8'h00))
        else $error("alarm code wrong");
    // Polls sit on second ticks, so two never come close together
    AST_POLL_PULSE: assert property (|poll_req |=> !(|poll_req) [*8])
        else $error("poll request too long");
    // State only moves after a received value or a register write
    AST_STATE_CAUSE: assert property ($changed(sensor_state) |->
        $past(|rx.valid) || !$past(hreadyout) || !$past(hreadyout, 2))
        else $error("state changed without cause");
    AST_ALARM_FALL: assert property ($fell(alarm_out.alarm) |->
        $past(|rx.valid) || $past(|rx.valid, 2) || !$past(hreadyout) || !$past(hreadyout, 2))
        else $error("alarm cleared without cause");
endmodule // bsens_assertions

/* sim/bsens_sender.sv */
`timescale 1ns/1ps
// Far-side bus devices: answer polls, or send on command
module bsens_sender (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [bsens_pkg::NSRC-1:0] poll_req,
    input wire logic mute,
    output bsens_pkg::sensor_rx_t rx
);
    logic [bsens_pkg::NSRC-1:0] req_v;
    logic [bsens_pkg::NSRC-1:0] req_d;
    logic [bsens_pkg::NSRC-1:0] hit;
    initial req_v = '0;
    initial req_d = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // One-bit values; idle value lines toggle so nothing reads as held
    always @(posedge clk) begin
        hit = req_v | (mute ? '0 : poll_req);
        if (!nrst) begin
            rx <= '0;
        end else begin
            rx.valid <= hit;
            rx.value <= (req_v & req_d) | (~req_v & ~rx.value);
        end
        req_v = '0;
    end
    // Queue one value for the next edge
    task automatic send(input int s, input logic v);
        @(negedge clk);
        req_v[s] = 1'b1;
        req_d[s] = v;
        @(posedge clk);
        #1;
    endtask
endmodule // bsens_sender

/* sim/bus_binary_sensor_timeout_tb.sv */
`timescale 1ns/1ps
module bus_binary_sensor_timeout_tb;
    logic clk;
    logic nrst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    bsens_pkg::sensor_rx_t rx;
    logic [bsens_pkg::NSRC-1:0] poll_req;
    logic [bsens_pkg::NSRC-1:0] sensor_state;
    bsens_pkg::alarm_out_t alarm_out;
    logic irq;
    logic mute;
    logic [31:0] q;
    time t0;
    int bad_count;
    int check_count;
    assign hready = hreadyout;
    bus_binary_sensor_timeout #(.TICK_CYCLES(10)) i_bus_binary_sensor_timeout (.clk(clk),
        .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx(rx), .poll_req(poll_req),
        .sensor_state(sensor_state), .alarm_out(alarm_out), .irq(irq));
    bsens_sender i_bsens_sender (.clk(clk), .nrst(nrst), .poll_req(poll_req), .mute(mute),
        .rx(rx));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Step past edges so outputs have settled
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Single AHB-Lite word; the master waits on hready, giving up after 50 cycles
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        q = hrdata;
        if (n >= 50) bad_count++;
        #1;
    endtask
    task automatic wait_alarm(input logic v, input int lim);
        int n;
        n = 0;
        while (alarm_out.alarm !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk(q, 32'h0000_0500);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        bus(1'b0, 32'h0000_003C, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        bus(1'b1, 32'h0000_0004, 32'h0012_0C0F);
        bus(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk(q, 32'h0012_0C0F);
        bus(1'b1, 32'h0000_0004, 32'h0000_0000);
        $display("test reset done");
    endtask
    // Win2 inverted, presence 1 disabled
    task automatic t_polarity();
        bus(1'b1, 32'h0000_0000, 32'h0000_0213);
        i_bsens_sender.send(0, 1'b1);
        i_bsens_sender.send(1, 1'b1);
        i_bsens_sender.send(2, 1'b1);
        i_bsens_sender.send(4, 1'b1);
        step(2);
        chk({27'h0, sensor_state}, 32'h0000_0011);
        i_bsens_sender.send(1, 1'b0);
        i_bsens_sender.send(4, 1'b0);
        step(2);
        bus(1'b0, 32'h0000_0020, 32'h0000_0000);
        chk(q & 32'h0000_001F, 32'h0000_0003);
        $display("test polarity done");
    endtask
    task automatic t_poll();
        bus(1'b1, 32'h0000_0008, 32'h0000_0005);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk(q, 32'h0000_001E);
        bus(1'b1, 32'h0000_000C, 32'h0000_FFFF);
        bus(1'b0, 32'h0000_000C, 32'h0000_0000);
        chk(q, 32'h0000_1C20);
        bus(1'b1, 32'h0000_000C, 32'h0000_001E);
        bus(1'b1, 32'h0000_0018, 32'h0000_001E);
        bus(1'b1, 32'h0000_0004, 32'h0000_0100);
        for (int i = 0; i < 400 && poll_req[4] !== 1'b1; i++) step(1);
        t0 = $time;
        step(1);
        for (int i = 0; i < 400 && poll_req[4] !== 1'b1; i++) step(1);
        chk(32'(($time - t0) / 8), 32'd300);
        step(700);
        chk({31'h0, alarm_out.alarm}, 32'h0000_0000);
        $display("test poll done");
    endtask
    task automatic t_stale();
        mute <= 1'b1;
        bus(1'b1, 32'h0000_002C, 32'h0000_001F);
        // Zero timeout first drops update marks left by the polls, so all go stale at once
        bus(1'b1, 32'h0000_0004, 32'h0000_0000);
        bus(1'b1, 32'h0000_0004, 32'h0000_0003);
        wait_alarm(1'b1, 80);
        chk({24'h0, alarm_out.code}, 32'h0000_0040);
        chk({31'h0, irq}, 32'h0000_0001);
        bus(1'b0, 32'h0000_0020, 32'h0000_0000);
        chk(q & 32'h0001_1F00, 32'h0001_1300);
        i_bsens_sender.send(0, 1'b1);
        step(2);
        chk({24'h0, alarm_out.code}, 32'h0000_0041);
        i_bsens_sender.send(1, 1'b1);
        i_bsens_sender.send(4, 1'b1);
        step(2);
        chk({31'h0, alarm_out.suspend}, 32'h0000_0000);
        // Restart a clean window so the next expiry marks all three sources together
        bus(1'b1, 32'h0000_0004, 32'h0000_0000);
        bus(1'b1, 32'h0000_0004, 32'h0000_0003);
        bus(1'b1, 32'h0000_0028, 32'h0000_1F1F);
        bus(1'b1, 32'h0000_002C, 32'h0000_0000);
        step(2);
        chk({31'h0, irq}, 32'h0000_0000);
        wait_alarm(1'b1, 80);
        chk({31'h0, alarm_out.suspend}, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        bus(1'b0, 32'h0000_0024, 32'h0000_0000);
        chk(q & 32'h0000_001F, 32'h0000_0013);
        bus(1'b1, 32'h0000_0000, 32'h0000_0212);
        step(2);
        chk({24'h0, alarm_out.code}, 32'h0000_0041);
        bus(1'b1, 32'h0000_0004, 32'h0000_0000);
        step(2);
        chk({31'h0, alarm_out.alarm}, 32'h0000_0000);
        step(60);
        chk({31'h0, alarm_out.alarm}, 32'h0000_0000);
        $display("test stale done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        mute = 1'b0;
        bad_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        step(1);
        t_reset();
        t_polarity();
        t_poll();
        t_stale();
        final_report();
    end
endmodule // bus_binary_sensor_timeout_tb
bind bus_binary_sensor_timeout bsens_assertions i_bsens_assertions (.clk(clk), .nrst(nrst),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .rx(rx), .poll_req(poll_req), .sensor_state(sensor_state), .alarm_out(alarm_out));
